// ==== logic/iba_internal_bus_arbiter.sv ====
// four-port pipelined internal bus arbiter with control register
//
// What this block does
// - pointed master granted at once when free
// - other requesters wait one pipeline cycle
// - immediate winner excluded from next pointer unless it is the only requester
// - fixed mode points at highest priority
// - round robin adds last finished master priority mod 4
// - finished master goes to twice its code mod 4, others shift by its code
// - bit 14 selects fixed, round robin reset
// - idle parks last or highest by bit 12
// - round robin ignores timeout and lockout fields
// - fixed winner keeps bus until transfers done
// - timeout enable counts denial cycles per master
// - lockout forces round robin until cleared
// - lockout limit is two to field value
// - two-bit priority field per master
// - reset order ethernet, dma, internal, core
// - duplicate priorities fall back to reset order
// - bit 25 lets dma elevate its priority
// - bit 24 drives dma wide byte count
//
// The implementer's own choices: the plain strobed port and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "iba_arbiter_cfg.svh"

module iba_internal_bus_arbiter #(
    parameter int LOCK_WIDTH = 16
) (
    input  wire logic                          clk,
    input  wire logic                          rst,
    input  wire logic [`IBA_ADDR_WIDTH-1:0]    regAddr,
    input  wire logic [31:0]                   regWriteData,
    input  wire logic                          regWrite,
    input  wire logic                          regRead,
    output logic [31:0]                        regReadData,
    input  wire iba_arbiter_pkg::iba_req_type  masterReq,
    input  wire logic                          addrPhaseFree,
    output logic [3:0]                         grant,
    output logic [1:0]                         arbPointer,
    output logic                               dma_bandwidth_boost_en,
    output logic                               dma_wide_byte_count
);

    logic [31:0]                    arbiter_control;
    logic [1:0]                     ownerIdx;
    logic                           ownerValid;
    logic [1:0]                     lastActive;
    logic [3:0][LOCK_WIDTH-1:0]     denyCount;
    logic                           lockActive;
    logic [1:0]                     rrBase;
    iba_arbiter_pkg::iba_prio_type  prio;
    iba_arbiter_pkg::iba_mode_type  mode;
    logic [3:0]                     pending;
    logic [1:0]                     next_pointer;
    logic [LOCK_WIDTH-1:0]          lockLimit;
    logic                           ownerBusy;
    logic                           immediate;

    // true when all four codes differ
    function automatic logic prio_unique(input logic [7:0] f);
        logic ok;
        ok = 1'b1;
        for (int i = 0; i < 4; i++) begin
            for (int j = i + 1; j < 4; j++) begin
                if (f[2*i +: 2] == f[2*j +: 2]) begin
                    ok = 1'b0;
                end
            end
        end
        return ok;
    endfunction

    // highest scoring requester among a set, ties go to the lower index
    function automatic logic [1:0] pick_best(input logic [3:0] set,
                                             input iba_arbiter_pkg::iba_prio_type score);
        logic [1:0] best;
        logic [2:0] bestScore;
        best = 2'h0;
        bestScore = 3'h0;
        for (int k = 0; k < 4; k++) begin
            if (set[k] && ({1'b0, score[k]} + 3'h1) > bestScore) begin
                best = 2'(k);
                bestScore = {1'b0, score[k]} + 3'h1;
            end
        end
        return best;
    endfunction

    // control register; writes only touch defined bits so reserved stay zero
    always_ff @(posedge clk) begin
        if (rst) begin
            arbiter_control <= `IBA_CTRL_RESET;
        end else if (regWrite && regAddr == `IBA_CTRL_OFFSET) begin
            arbiter_control <= regWriteData & `IBA_CTRL_WRITE_MASK;
        end
    end

    // read data stands the cycle after the strobe only
    always_ff @(posedge clk) begin
        if (rst) begin
            regReadData <= 32'h0000_0000;
        end else if (regRead) begin
            case (regAddr)
                `IBA_CTRL_OFFSET:   regReadData <= arbiter_control;
                `IBA_STATUS_OFFSET: regReadData <= {24'h00_0000, lockActive, ownerValid,
                                                    lastActive, ownerIdx, arbPointer};
                default:            regReadData <= 32'h0000_0000;
            endcase
        end else begin
            regReadData <= 32'h0000_0000;
        end
    end

    assign dma_wide_byte_count    = arbiter_control[`IBA_WIDE_BIT];
    assign dma_bandwidth_boost_en = arbiter_control[`IBA_BOOST_BIT];

    // programmed priorities, or reset order when codes collide
    always_comb begin
        logic [7:0] field;
        field = {arbiter_control[`IBA_ETH_PRI_LSB +: 2], arbiter_control[`IBA_DMA_PRI_LSB +: 2],
                 arbiter_control[`IBA_INT_PRI_LSB +: 2], arbiter_control[`IBA_CORE_PRI_LSB +: 2]};
        if (!prio_unique(field)) begin
            field = `IBA_DEFAULT_PRI;
        end
        prio = field;
    end

    // lockout only matters in fixed mode with timeout enabled
    assign lockLimit = LOCK_WIDTH'(1) << arbiter_control[`IBA_LOCK_LSB +: 4];
    assign mode = (arbiter_control[`IBA_FIXED_BIT] && !lockActive) ?
                  iba_arbiter_pkg::IBA_FIXED_ARB : iba_arbiter_pkg::IBA_ROUND_ARB;

    // owner holds bus until it reports completion
    assign ownerBusy = ownerValid && !masterReq.complete[ownerIdx];
    assign immediate = addrPhaseFree && !ownerBusy && masterReq.request[arbPointer];

    // one-hot grant, only to the pointed master
    always_comb begin
        grant = 4'h0;
        if (immediate) begin
            grant[arbPointer] = 1'b1;
        end
    end

    // requesters left for the next pointer once the immediate winner is removed
    always_comb begin
        pending = masterReq.request;
        if (immediate) begin
            pending[arbPointer] = 1'b0;
        end
    end

    // next pointer: fixed, round robin or park
    always_comb begin
        iba_arbiter_pkg::iba_prio_type eff;
        logic [1:0] top;
        eff = prio;
        if (arbiter_control[`IBA_BOOST_BIT] && masterReq.dmaUrgent) begin
            eff[2] = 2'h3;
        end
        top = pick_best(4'hf, prio);
        if (mode == iba_arbiter_pkg::IBA_ROUND_ARB) begin
            for (int m = 0; m < 4; m++) begin
                eff[m] = 2'(eff[m] + prio[rrBase]);
            end
        end
        if (pending != 4'h0) begin
            next_pointer = pick_best(pending, eff);
        end else if (masterReq.request != 4'h0) begin
            next_pointer = arbPointer;
        end else if (arbiter_control[`IBA_PARK_BIT]) begin
            next_pointer = top;
        end else begin
            next_pointer = lastActive;
        end
    end

    // pointer is registered: a non-pointed requester waits at least a cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            arbPointer <= `IBA_CORE_IDX;
        end else if (!ownerBusy) begin
            arbPointer <= next_pointer;
        end
    end

    // ownership and the round robin base rotate on completion
    always_ff @(posedge clk) begin
        if (rst) begin
            ownerValid <= 1'b0;
            ownerIdx   <= `IBA_CORE_IDX;
            lastActive <= `IBA_CORE_IDX;
            rrBase     <= `IBA_CORE_IDX;
        end else begin
            if (immediate) begin
                ownerValid <= 1'b1;
                ownerIdx   <= arbPointer;
                lastActive <= arbPointer;
            end else if (ownerValid && masterReq.complete[ownerIdx]) begin
                ownerValid <= 1'b0;
            end
            if (ownerValid && masterReq.complete[ownerIdx]) begin
                rrBase <= ownerIdx;
            end
        end
    end

    // denial counters saturate so a long wait cannot wrap back under the limit
    always_ff @(posedge clk) begin
        if (rst || !arbiter_control[`IBA_TIMEOUT_BIT] || !arbiter_control[`IBA_FIXED_BIT]) begin
            denyCount <= '0;
        end else begin
            for (int n = 0; n < 4; n++) begin
                if (masterReq.request[n] && !grant[n]) begin
                    if (denyCount[n] != {LOCK_WIDTH{1'b1}}) begin
                        denyCount[n] <= denyCount[n] + LOCK_WIDTH'(1);
                    end
                end else begin
                    denyCount[n] <= '0;
                end
            end
        end
    end

    // lock stays until every counter has dropped below the limit
    always_comb begin
        lockActive = 1'b0;
        for (int p = 0; p < 4; p++) begin
            if (denyCount[p] >= lockLimit) begin
                lockActive = 1'b1;
            end
        end
    end

endmodule
`default_nettype wire

// ==== logic/iba_arbiter_cfg.svh ====
// register layout, reset value and field positions of the arbiter control register
`ifndef IBA_ARBITER_CFG_SVH
`define IBA_ARBITER_CFG_SVH

`define IBA_CTRL_OFFSET      8'h00
`define IBA_STATUS_OFFSET    8'h04
`define IBA_ADDR_WIDTH       8
// ethernet=11, dma=10, internal=01, core=00
`define IBA_CTRL_RESET       32'h00e1_0000
`define IBA_CTRL_WRITE_MASK  32'h03ff_7f00
`define IBA_BOOST_BIT        25
`define IBA_WIDE_BIT         24
`define IBA_ETH_PRI_LSB      22
`define IBA_DMA_PRI_LSB      20
`define IBA_CORE_PRI_LSB     18
`define IBA_INT_PRI_LSB      16
`define IBA_FIXED_BIT        14
`define IBA_TIMEOUT_BIT      13
`define IBA_PARK_BIT         12
`define IBA_LOCK_LSB         8
// fallback codes packed as {ethernet, dma, internal, core}, so internal=01 sits above core=00
`define IBA_DEFAULT_PRI      8'he4
`define IBA_CORE_IDX         2'h0
`define IBA_NUM_MASTERS      4

`endif

// ==== logic/iba_arbiter_pkg.sv ====
// types shared by the internal bus arbiter
package iba_arbiter_pkg;
    // per-master priority codes, index 0 core, 1 internal, 2 dma, 3 ethernet
    typedef logic [3:0][1:0] iba_prio_type;

    // request bundle from the four masters
    typedef struct packed {
        logic [3:0] request;     // master wants the bus
        logic [3:0] complete;    // master finished its current transfer
        logic       dmaUrgent;   // dma bandwidth control asks for elevation
    } iba_req_type;

    typedef enum logic [1:0] {
        IBA_FIXED_ARB  = 2'b01,
        IBA_ROUND_ARB  = 2'b10
    } iba_mode_type;
endpackage

// ==== verification/iba_arbiter_checker.sv ====
// port assertions for the bus arbiter
`timescale 1ns/100ps
`default_nettype none
`include "iba_arbiter_cfg.svh"
module iba_arbiter_checker #(parameter int LOCK_WIDTH = 16) (
    input wire logic                         clk,
    input wire logic                         rst,
    input wire logic [`IBA_ADDR_WIDTH-1:0]   regAddr,
    input wire logic [31:0]                  regWriteData,
    input wire logic                         regWrite,
    input wire logic                         regRead,
    input wire logic [31:0]                  regReadData,
    input wire iba_arbiter_pkg::iba_req_type masterReq,
    input wire logic                         addrPhaseFree,
    input wire logic [3:0]                   grant,
    input wire logic [1:0]                   arbPointer,
    input wire logic                         dma_bandwidth_boost_en,
    input wire logic                         dma_wide_byte_count
);
    // one domain, so clock and reset are stated once
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic ctrlWr;
    // only a control write may move the dma controls
    assign ctrlWr = regWrite && regAddr == `IBA_CTRL_OFFSET;
    AST_ONE_GRANT: assert property ($onehot0(grant)) else $error("two grants");
    AST_GRANT_PTR: assert property (grant != 4'h0 |-> grant == 4'h1 << arbPointer)
        else $error("grant off pointer");
    AST_GRANT_CAUSE: assert property (
        grant != 4'h0 |-> addrPhaseFree && (grant & masterReq.request) != 4'h0)
        else $error("grant without cause");
    AST_RSVD_ZERO: assert property ($past(regRead) && $past(regAddr) == 8'h00
        |-> (regReadData & ~`IBA_CTRL_WRITE_MASK) == 32'h0) else $error("reserved bit set");
    AST_BOOST_WR: assert property (
        ctrlWr |=> dma_bandwidth_boost_en == $past(regWriteData[25])) else $error("boost");
    AST_WIDE_WR: assert property (
        ctrlWr |=> dma_wide_byte_count == $past(regWriteData[24])) else $error("width");
    AST_DMA_HOLD: assert property (
        !ctrlWr |=> $stable({dma_bandwidth_boost_en, dma_wide_byte_count})) else $error("moved");
    AST_PARK_STILL: assert property (
        (masterReq.request == 4'h0 && !regWrite)[*8] |=> $stable(arbPointer))
        else $error("park moved");
endmodule
bind iba_internal_bus_arbiter iba_arbiter_checker #(.LOCK_WIDTH(LOCK_WIDTH)) i_chk (
    .clk, .rst, .regAddr, .regWriteData, .regWrite, .regRead, .regReadData, .masterReq,
    .addrPhaseFree, .grant, .arbPointer, .dma_bandwidth_boost_en, .dma_wide_byte_count);
`default_nettype wire

// ==== verification/iba_master_model.sv ====
// model of the four requesting masters
`timescale 1ns/100ps
`default_nettype none
module iba_master_model (
    input wire logic                        clk,
    input wire logic                        rst,
    input wire logic [3:0]                  wants,
    input wire logic                        urgent,
    input wire logic [3:0]                  grant,
    output var iba_arbiter_pkg::iba_req_type masterReq
);
    // requests stay up while wanted; every transfer ends the cycle after its grant
    always_ff @(posedge clk) begin
        if (rst) begin
            masterReq <= '0;
        end else begin
            masterReq.request <= wants;
            masterReq.complete <= grant;
            masterReq.dmaUrgent <= urgent;
        end
    end
endmodule
`default_nettype wire

// ==== verification/tb.sv ====
// self-checking bench for the bus arbiter
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic        clk = 1'b0, rst = 1'b1, regWrite = 1'b0, regRead = 1'b0;
    logic        addrPhaseFree = 1'b1, urgent = 1'b0;
    logic        dma_bandwidth_boost_en, dma_wide_byte_count;
    logic [7:0]  regAddr = 8'h00;
    logic [31:0] regWriteData = 32'h0, regReadData;
    logic [3:0]  wants = 4'h0, grant, seen;
    logic [1:0]  arbPointer, lastGrant = 2'h0;
    int          failures = 0, total_checks = 0, cyc = 0;
    iba_arbiter_pkg::iba_req_type masterReq;
    // rows: control word, wanting masters, masters granted, parked pointer
    logic [31:0] rowCtrl [10] = '{32'h00e15000, 32'h00e17f00, 32'h00e17200,
        32'h00e11000, 32'h00e13f00, 32'h028d4000, 32'h008d4000, 32'h00005000, 32'h002d5000,
        32'h00b10000};
    logic [3:0]  rowWants [10] = '{4'hf, 4'hf, 4'hf, 4'hf, 4'hf, 4'hc, 4'hc, 4'hf, 4'hf, 4'h2};
    // the immediate winner leaves the next choice, so the runner-up alternates with it
    logic [3:0]  rowSeen [10] = '{4'hc, 4'hc, 4'hf, 4'hf, 4'hf, 4'hc, 4'hc, 4'hc, 4'h5, 4'h2};
    logic [1:0]  rowPtr [10] = '{2'h3, 2'h3, 2'h3, 2'h3, 2'h3, 2'h2, 2'h3, 2'h3, 2'h0, 2'h1};

    iba_internal_bus_arbiter i_dut (.clk, .rst, .regAddr, .regWriteData, .regWrite, .regRead,
        .regReadData, .masterReq, .addrPhaseFree, .grant, .arbPointer, .dma_bandwidth_boost_en,
        .dma_wide_byte_count);
    iba_master_model i_model (.clk, .rst, .wants, .urgent, .grant, .masterReq);

    // 200 MHz clock
    initial begin
        forever #2.5 clk = ~clk;
    end
    // last master seen entering the address phase, for park-on-last rows
    always @(posedge clk) begin
        if (grant != 4'h0) begin
            lastGrant <= {grant[3] | grant[2], grant[3] | grant[1]};
        end
    end
    // watchdog; the address phase is taken one cycle in eight
    always @(posedge clk) begin
        cyc <= cyc + 1;
        addrPhaseFree <= cyc[2:0] != 3'h5;
        if (cyc == 4000) begin
            failures++;
            end_sim();
        end
    end
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask
    // strobes rise on the calling edge, so calls may follow with no gap
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        regAddr <= a;
        regWriteData <= d;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        @(negedge clk);
        chk("read data", exp, regReadData);
        @(posedge clk);
    endtask
    task automatic end_sim();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // arbitration table, then registers, then a reset in mid-run
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(8'h00, 32'h00e10000);
        for (int r = 0; r < 10; r++) begin
            wr(8'h00, rowCtrl[r]);
            repeat (2) @(posedge clk);
            wants <= rowWants[r];
            urgent <= (r == 5 || r == 6);
            repeat (20) @(posedge clk);
            seen = 4'h0;
            repeat (100) begin
                @(posedge clk);
                seen = seen | grant;
            end
            chk("granted", 32'(rowSeen[r]), 32'(seen));
            wants <= 4'h0;
            repeat (12) @(posedge clk);
            chk("parked", 32'(rowCtrl[r][12] ? rowPtr[r] : lastGrant), 32'(arbPointer));
            $display("arbitration row %0d done", r);
        end
        wr(8'h00, 32'hffffffff);
        rd(8'h00, 32'h03ff7f00);
        chk("dma controls", 32'h3, {30'h0, dma_bandwidth_boost_en, dma_wide_byte_count});
        wr(8'h08, 32'h0);
        rd(8'h00, 32'h03ff7f00);
        rd(8'h08, 32'h0);
        wr(8'h00, 32'h00e10000);
        rd(8'h00, 32'h00e10000);
        chk("dma controls", 32'h0, {30'h0, dma_bandwidth_boost_en, dma_wide_byte_count});
        $display("register test done");
        wr(8'h00, 32'h00e17000);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(8'h00, 32'h00e10000);
        chk("reset pointer", 32'h0, 32'(arbPointer));
        $display("reset test done");
        end_sim();
    end
endmodule
`default_nettype wire
